// ### inc/tff_pkg.sv
// How it works
// - Format memory read in order picks source
// - Each sample is eight bits, shifted serially
// - A minor frame holds exactly 128 words
// - Fixed words sit at fixed slot positions
// - Major frame spans 256 minor frames
// - Submultiplex cycle restarts every 64 frames
// - Serial output runs at 40 kbit/s
// - Fixed slots bypass the input multiplexer
// - Format memory: 128 locations of 8 bits
package tff_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 50_000_000;        // System clock rate
    localparam int BIT_RATE_BPS  = 40_000;            // Telemetry readout rate
    localparam int BIT_CYCLES    = CLK_HZ / BIT_RATE_BPS; // Clocks per bit
    localparam int DIV_W         = 11;                // Divider width

    // ------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------
    localparam int WORD_BITS     = 8;                 // Bits per word
    localparam int FRAME_WORDS   = 128;               // Words per minor frame
    localparam int POS_W         = 7;                 // Word position width
    localparam int FCNT_W        = 8;                 // Minor frames per major: 256
    localparam int SUBMUX_W      = 6;                 // Submux cycle: 64 frames
    localparam int SEL_W         = 6;                 // Source address bits

    // ------------------------------------------------------------
    // Format memory location fields
    // ------------------------------------------------------------
    localparam int FMT_SEL_LSB   = 0;                 // Source address field
    localparam int FMT_SYNC_BIT  = 6;                 // Sync pulse enable bit

    // ------------------------------------------------------------
    // Fixed word positions
    // ------------------------------------------------------------
    localparam logic [6:0] POS_FCNT   = 7'h3c;        // Frame counter, word 60
    localparam logic [6:0] POS_GRP0   = 7'h3d;        // Status group, word 61
    localparam logic [6:0] POS_GRP1   = 7'h3e;        // Status group, word 62
    localparam logic [6:0] POS_GRP2   = 7'h3f;        // Status group, word 63
    localparam logic [6:0] POS_SYNC0  = 7'h7d;        // Frame sync, word 125
    localparam logic [6:0] POS_SYNC1  = 7'h7e;        // Frame sync, word 126
    localparam logic [6:0] POS_SYNC2  = 7'h7f;        // Frame sync, word 127

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] BITCNT_RST = 3'h7;         // Next edge starts a word
    localparam logic [6:0] POS_RST    = 7'h7f;        // Next word is word 0
    localparam logic [7:0] FCNT_RST   = 8'hff;        // First frame counts zero

    // Status group content, chosen by frame counter low bits
    typedef enum logic [1:0] {
        TFF_GRP_CLOCK,                                // Spacecraft clock
        TFF_GRP_ADDR,                                 // Memory readout, addresses
        TFF_GRP_STATUS,                               // Status register
        TFF_GRP_CMD                                   // Memory readout, command
    } tff_grp_t;

endpackage

// ### hdl/tff_formatter.sv
`timescale 1ns/10ps
module tff_formatter
    import tff_pkg::*;
#(
    parameter int         BIT_DIV = BIT_CYCLES,       // Clocks per serial bit
    parameter logic [7:0] SYNC_W0 = 8'hfa,            // Sync word pattern, plain default
    parameter logic [7:0] SYNC_W1 = 8'hf3,            // Sync word pattern, plain default
    parameter logic [7:0] SYNC_W2 = 8'h20             // Sync word pattern, plain default
)
(
    input  wire logic              clock,             // System clock
    input  wire logic              nrst,              // Async reset, active low
    input  wire logic              fmt_wr,            // Format memory write strobe
    input  wire logic [POS_W-1:0]  fmt_addr,          // Format memory write location
    input  wire logic [7:0]        fmt_wdata,         // Format memory write data
    input  wire logic [7:0]        sample_in,         // Converted sample of selected source
    input  wire logic [23:0]       sc_clock,          // Spacecraft clock value
    input  wire logic [23:0]       status_bits,       // Spacecraft status register
    input  wire logic [7:0]        indirect_addr,     // Indirect address register
    input  wire logic [7:0]        execute_addr,      // Execute address register
    input  wire logic [15:0]       command_reg,       // Command register
    output logic                   tlm_bit_r,         // Serial telemetry data
    output logic                   tlm_bit_stb_r,     // Pulse when a new bit starts
    output logic [SEL_W-1:0]       src_sel_r,         // Source address for next slot
    output logic                   mux_en_r,          // Multiplexer enabled for next slot
    output logic                   sync_pulse_en_r,   // Sync pulse enable for next slot
    output logic [POS_W-1:0]       word_pos_r,        // Word slot now on the line
    output logic [FCNT_W-1:0]      frame_cnt_r,       // Minor frame counter
    output logic                   minor_start_r,     // Pulse at word 0 of a frame
    output logic                   major_start_r,     // Pulse at frame 0 word 0
    output logic                   submux_start_r     // Pulse at each 64-frame cycle
);

    // ------------------------------------------------------------
    // Storage and internal state
    // ------------------------------------------------------------
    logic [7:0]        fmt_mem [FRAME_WORDS];         // Format memory
    logic [DIV_W-1:0]  div_r;                         // Bit-rate divider
    logic              bit_en;                        // One-cycle bit enable
    logic [2:0]        bit_cnt_r;                     // Bit within word
    logic [7:0]        shreg_r;                       // Output shift register
    logic              word_end;                      // Last bit of a slot ends
    logic [POS_W-1:0]  pos_nxt;                       // Slot about to start
    logic [POS_W-1:0]  pre_pos;                       // Slot whose source is prefetched
    logic [7:0]        pre_loc;                       // Prefetched format location
    logic [7:0]        word_nxt;                      // Content of the starting slot
    logic [7:0]        readout;                       // Format memory readout word
    tff_grp_t          grp;                           // Status group selection

    // True where a slot carries an internally made word
    function automatic logic is_fixed(input logic [POS_W-1:0] pos);
        return (pos == POS_FCNT) || (pos == POS_GRP0) || (pos == POS_GRP1) ||
               (pos == POS_GRP2) || (pos == POS_SYNC0) || (pos == POS_SYNC1) ||
               (pos == POS_SYNC2);
    endfunction

    // ------------------------------------------------------------
    // Format memory
    // ------------------------------------------------------------

    // Write port; contents are not reset, so load before relying on them
    always_ff @(posedge clock)
    begin
        if (fmt_wr)
        begin
            fmt_mem[fmt_addr] <= fmt_wdata;
        end
    end

    // ------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------

    // Divider makes the one-cycle bit enable
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            div_r <= '0;
        end
        else if (bit_en)
        begin
            div_r <= '0;
        end
        else
        begin
            div_r <= div_r + 1'b1;
        end
    end

    assign bit_en   = (div_r == DIV_W'(BIT_DIV - 1));
    assign word_end = bit_en && (bit_cnt_r == 3'h7);

    // Bit counter inside a word
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_cnt_r <= BITCNT_RST;
        end
        else if (bit_en)
        begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Word content
    // ------------------------------------------------------------

    // Position arithmetic wraps at 128 by width alone
    assign pos_nxt = word_pos_r + 1'b1;
    assign pre_pos = pos_nxt + 1'b1;
    assign pre_loc = fmt_mem[pre_pos];
    assign readout = fmt_mem[frame_cnt_r[POS_W-1:0]]; // One location per frame
    assign grp     = tff_grp_t'(frame_cnt_r[1:0]);

    // Fixed slots are built here; other slots take the sampled word
    always_comb
    begin
        word_nxt = sample_in;
        unique case (pos_nxt)
            POS_FCNT:  word_nxt = frame_cnt_r;
            POS_SYNC0: word_nxt = SYNC_W0;
            POS_SYNC1: word_nxt = SYNC_W1;
            POS_SYNC2: word_nxt = SYNC_W2;
            POS_GRP0:
            begin
                unique case (grp)
                    TFF_GRP_CLOCK:  word_nxt = sc_clock[23:16];
                    TFF_GRP_ADDR:   word_nxt = readout;
                    TFF_GRP_STATUS: word_nxt = status_bits[23:16];
                    TFF_GRP_CMD:    word_nxt = readout;
                endcase
            end
            POS_GRP1:
            begin
                unique case (grp)
                    TFF_GRP_CLOCK:  word_nxt = sc_clock[15:8];
                    TFF_GRP_ADDR:   word_nxt = indirect_addr;
                    TFF_GRP_STATUS: word_nxt = status_bits[15:8];
                    TFF_GRP_CMD:    word_nxt = command_reg[15:8];
                endcase
            end
            POS_GRP2:
            begin
                unique case (grp)
                    TFF_GRP_CLOCK:  word_nxt = sc_clock[7:0];
                    TFF_GRP_ADDR:   word_nxt = execute_addr;
                    TFF_GRP_STATUS: word_nxt = status_bits[7:0];
                    TFF_GRP_CMD:    word_nxt = command_reg[7:0];
                endcase
            end
            default: word_nxt = sample_in;            // Multiplexed slot
        endcase
    end

    // ------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------

    // MSB first; a new word loads at the slot boundary
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            shreg_r   <= '0;
            tlm_bit_r <= 1'b0;
        end
        else if (word_end)
        begin
            tlm_bit_r <= word_nxt[WORD_BITS-1];
            shreg_r   <= {word_nxt[WORD_BITS-2:0], 1'b0};
        end
        else if (bit_en)
        begin
            tlm_bit_r <= shreg_r[WORD_BITS-1];
            shreg_r   <= {shreg_r[WORD_BITS-2:0], 1'b0};
        end
    end

    // Bit strobe marks each bit start
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tlm_bit_stb_r <= 1'b0;
        end
        else
        begin
            tlm_bit_stb_r <= bit_en;
        end
    end

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------

    // Selection leads the line by one slot so the source settles a full word
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            src_sel_r       <= '0;
            mux_en_r        <= 1'b0;
            sync_pulse_en_r <= 1'b0;
        end
        else if (word_end)
        begin
            if (is_fixed(pre_pos))
            begin
                src_sel_r       <= '0;
                mux_en_r        <= 1'b0;
                sync_pulse_en_r <= 1'b0;
            end
            else
            begin
                src_sel_r       <= pre_loc[FMT_SEL_LSB +: SEL_W];
                mux_en_r        <= 1'b1;
                sync_pulse_en_r <= pre_loc[FMT_SYNC_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Word and frame counting
    // ------------------------------------------------------------

    // Word position on the line
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            word_pos_r <= POS_RST;
        end
        else if (word_end)
        begin
            word_pos_r <= pos_nxt;
        end
    end

    // Frame counter wraps after 256 frames, marking the major frame
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            frame_cnt_r <= FCNT_RST;
        end
        else if (word_end && (pos_nxt == '0))
        begin
            frame_cnt_r <= frame_cnt_r + 1'b1;
        end
    end

    // Frame boundary pulses
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            minor_start_r  <= 1'b0;
            major_start_r  <= 1'b0;
            submux_start_r <= 1'b0;
        end
        else
        begin
            minor_start_r  <= word_end && (pos_nxt == '0);
            major_start_r  <= word_end && (pos_nxt == '0) &&
                              (frame_cnt_r == FCNT_RST);
            submux_start_r <= word_end && (pos_nxt == '0) &&
                              (frame_cnt_r[SUBMUX_W-1:0] == '1);
        end
    end

endmodule // tff_formatter

// ### test/tff_formatter_props.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Stream timing checker
// ------------------------------------------------------------
module tff_formatter_props
    import tff_pkg::*;
#(
    parameter int BIT_DIV = BIT_CYCLES               // Clocks per bit
)
(
    input wire logic              clock,              // Clock
    input wire logic              nrst,               // Reset, active low
    input wire logic              fmt_wr,             // Format write
    input wire logic              tlm_bit_r,          // Serial data
    input wire logic              tlm_bit_stb_r,      // Bit strobe
    input wire logic [SEL_W-1:0]  src_sel_r,          // Source address
    input wire logic              mux_en_r,           // Mux enable
    input wire logic [POS_W-1:0]  word_pos_r,         // Slot on line
    input wire logic [FCNT_W-1:0] frame_cnt_r,        // Frame counter
    input wire logic              minor_start_r,      // Frame pulse
    input wire logic              major_start_r,      // Major pulse
    input wire logic              submux_start_r      // Submux pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [10:0] gap_r;                               // Clocks since last strobe
    logic        seen_r;                              // A strobe was seen
    logic [2:0]  nbit_r;                              // Strobes modulo a word
    // Spacing counters; the first gap after reset is not a full bit, so seen_r gates it
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            gap_r  <= 11'h0;
            seen_r <= 1'b0;
            nbit_r <= 3'h0;
        end
        else
        begin
            gap_r  <= tlm_bit_stb_r ? 11'h0 : gap_r + 11'h1;
            seen_r <= seen_r | tlm_bit_stb_r;
            nbit_r <= nbit_r + {2'h0, tlm_bit_stb_r};
        end
    end
    property p_bit_period;
        tlm_bit_stb_r && seen_r |-> gap_r == 11'(BIT_DIV - 1);
    endproperty
    a_bit_period: assert property (p_bit_period) else $error("Bit spacing wrong");
    property p_bit_hold;
        !tlm_bit_stb_r |-> $stable(tlm_bit_r);
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("Bit changed mid period");
    property p_word_bits;
        $changed(word_pos_r) |-> tlm_bit_stb_r && nbit_r == 3'h0;
    endproperty
    a_word_bits: assert property (p_word_bits) else $error("Word not eight bits");
    property p_word_step;
        $changed(word_pos_r) |-> word_pos_r == $past(word_pos_r) + 7'h1;
    endproperty
    a_word_step: assert property (p_word_step) else $error("Slot skipped");
    property p_fcnt_step;
        $changed(frame_cnt_r) |-> minor_start_r && frame_cnt_r == $past(frame_cnt_r) + 8'h1;
    endproperty
    a_fcnt_step: assert property (p_fcnt_step) else $error("Frame count step wrong");
    property p_minor;
        minor_start_r |-> word_pos_r == 7'h0 && $changed(frame_cnt_r);
    endproperty
    a_minor: assert property (p_minor) else $error("Frame start misplaced");
    property p_major;
        major_start_r == (minor_start_r && frame_cnt_r == 8'h0);
    endproperty
    a_major: assert property (p_major) else $error("Major start wrong");
    property p_submux;
        submux_start_r == (minor_start_r && frame_cnt_r[5:0] == 6'h0);
    endproperty
    a_submux: assert property (p_submux) else $error("Submux start wrong");
    property p_fixed;
        word_pos_r inside {7'h3b, 7'h3c, 7'h3d, 7'h3e, 7'h7c, 7'h7d, 7'h7e}
            |-> !mux_en_r && src_sel_r == 6'h0;
    endproperty
    a_fixed: assert property (p_fixed) else $error("Mux used in fixed slot");
    c_minor: cover property (minor_start_r);
    c_group3: cover property (minor_start_r && frame_cnt_r == 8'h3);
    c_write: cover property (fmt_wr);
endmodule // tff_formatter_props

bind tff_formatter tff_formatter_props #(.BIT_DIV(BIT_DIV)) u_props (
    .clock(clock), .nrst(nrst), .fmt_wr(fmt_wr), .tlm_bit_r(tlm_bit_r),
    .tlm_bit_stb_r(tlm_bit_stb_r), .src_sel_r(src_sel_r), .mux_en_r(mux_en_r),
    .word_pos_r(word_pos_r), .frame_cnt_r(frame_cnt_r), .minor_start_r(minor_start_r),
    .major_start_r(major_start_r), .submux_start_r(submux_start_r));

// ### test/tff_source_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Data sources and downlink receiver
// ------------------------------------------------------------
module tff_source_model
    import tff_pkg::*;
(
    input  wire logic              clock,             // Clock
    input  wire logic              nrst,              // Reset, active low
    input  wire logic              tlm_bit_r,         // Serial data
    input  wire logic              tlm_bit_stb_r,     // Bit strobe
    input  wire logic [SEL_W-1:0]  src_sel_r,         // Source address
    input  wire logic              mux_en_r,          // Mux enable
    input  wire logic              sync_pulse_en_r,   // Sync enable
    input  wire logic [POS_W-1:0]  word_pos_r,        // Slot on line
    input  wire logic [FCNT_W-1:0] frame_cnt_r,       // Frame counter
    output logic [7:0]             sample_in,         // Source sample
    output logic [7:0]             rx_word_r,         // Received word
    output logic [POS_W-1:0]       rx_pos_r,          // Its slot
    output logic [FCNT_W-1:0]      rx_fc_r,           // Its frame count
    output logic                   rx_vld_r           // Word complete
);
    logic [7:0] last_r;                               // Last sample shown
    logic [2:0] nbit_r;                               // Bits received
    // Deselected sources float: show the inverse so a stale value never matches
    always_comb sample_in = mux_en_r ? {1'b1, sync_pulse_en_r, src_sel_r} : ~last_r;
    always_ff @(posedge clock) last_r <= sample_in;
    // Deserialiser, MSB first; a reset drops any part word
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            nbit_r   <= 3'h0;
            rx_vld_r <= 1'b0;
        end
        else
        begin
            rx_vld_r <= tlm_bit_stb_r && nbit_r == 3'h7;
            if (tlm_bit_stb_r)
            begin
                nbit_r    <= nbit_r + 3'h1;
                rx_word_r <= {rx_word_r[6:0], tlm_bit_r};
                if (nbit_r == 3'h0)
                begin
                    rx_pos_r <= word_pos_r;
                    rx_fc_r  <= frame_cnt_r;
                end
            end
        end
    end
endmodule // tff_source_model

// ### test/tb_telemetry_frame_formatter.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Formatter bench
// ------------------------------------------------------------
module tb_telemetry_frame_formatter;
    import tff_pkg::*;
    localparam logic [23:0] SCK = 24'h1a2b3c;         // Clock value
    localparam logic [23:0] STS = 24'h4d5e6f;         // Status value
    localparam logic [15:0] CMD = 16'h93a4;           // Command value
    localparam logic [7:0]  IND = 8'h71;              // Indirect address
    localparam logic [7:0]  EXE = 8'h82;              // Execute address
    logic              clock, nrst, fmt_wr;           // Clock, reset, write
    logic [POS_W-1:0]  fmt_addr, rx_pos, word_pos;    // Slots
    logic [7:0]        fmt_wdata, sample_in, rx_word; // Bytes
    logic [FCNT_W-1:0] frame_cnt, rx_fc;              // Frame counts
    logic [SEL_W-1:0]  src_sel;                       // Selection
    logic              tlm_bit, tlm_stb, mux_en, sync_en, rx_vld; // Stream
    logic [7:0]        fmt_mem [128];                 // Expected memory
    int                err_total, compares;           // Counters
    // Short bit period keeps a frame at 4096 clocks
    tff_formatter #(.BIT_DIV(4), .SYNC_W0(8'h5a), .SYNC_W1(8'hc3), .SYNC_W2(8'h0f)) dut (
        .clock(clock), .nrst(nrst), .fmt_wr(fmt_wr), .fmt_addr(fmt_addr),
        .fmt_wdata(fmt_wdata), .sample_in(sample_in), .sc_clock(SCK), .status_bits(STS),
        .indirect_addr(IND), .execute_addr(EXE), .command_reg(CMD), .tlm_bit_r(tlm_bit),
        .tlm_bit_stb_r(tlm_stb), .src_sel_r(src_sel), .mux_en_r(mux_en),
        .sync_pulse_en_r(sync_en), .word_pos_r(word_pos), .frame_cnt_r(frame_cnt),
        .minor_start_r(), .major_start_r(), .submux_start_r());
    tff_source_model u_model (.clock(clock), .nrst(nrst), .tlm_bit_r(tlm_bit),
        .tlm_bit_stb_r(tlm_stb), .src_sel_r(src_sel), .mux_en_r(mux_en),
        .sync_pulse_en_r(sync_en), .word_pos_r(word_pos), .frame_cnt_r(frame_cnt),
        .sample_in(sample_in), .rx_word_r(rx_word), .rx_pos_r(rx_pos), .rx_fc_r(rx_fc),
        .rx_vld_r(rx_vld));
    // 50 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    // Next received word, bounded so a dead stream cannot hang here
    task automatic get_word;
        int n;
        n = 0;
        @(posedge clock);
        while (rx_vld !== 1'b1 && n < 100)
        begin
            @(posedge clock);
            n++;
        end
        // A dead stream is a failure, not a silent return
        if (rx_vld !== 1'b1)
        begin
            $display("MISMATCH rx_vld expected 1 seen %b", rx_vld);
            err_total++;
        end
    endtask
    // Expected word: fixed slots take no source from the memory (word 61 reads location f in odd frames), others carry the chosen source
    function automatic logic [7:0] exp_word(input logic [6:0] p, input logic [7:0] f);
        logic [31:0] g62;
        logic [31:0] g63;
        g62 = {CMD[15:8], STS[15:8], IND, SCK[15:8]};
        g63 = {CMD[7:0], STS[7:0], EXE, SCK[7:0]};
        case (p)
            7'h3c: return f;
            7'h3d: return f[0] ? fmt_mem[f[6:0]] : (f[1] ? STS[23:16] : SCK[23:16]);
            7'h3e: return g62[{f[1:0], 3'h0} +: 8];
            7'h3f: return g63[{f[1:0], 3'h0} +: 8];
            7'h7d: return 8'h5a;
            7'h7e: return 8'hc3;
            7'h7f: return 8'h0f;
            default: return {1'b1, fmt_mem[p][6:0]};
        endcase
    endfunction
    // Back-to-back writes of every location, bit 7 set in some
    task automatic t_load_format;
        for (int i = 0; i < 128; i++)
        begin
            @(posedge clock);
            fmt_wr    <= 1'b1;
            fmt_addr  <= 7'(i);
            fmt_wdata <= 8'(i * 37 + 17);
            fmt_mem[i] = 8'(i * 37 + 17);
        end
        @(posedge clock);
        fmt_wr <= 1'b0;
    endtask
    // Whole frames from frame f0 on, word by word
    task automatic t_frames(input logic [7:0] f0, input int nf);
        int n;
        n = 0;
        get_word;
        while (!(rx_pos === 7'h0 && rx_fc === f0) && n < 300)
        begin
            get_word;
            n++;
        end
        // Frame start never found counts as a mismatch
        if (n >= 300)
        begin
            $display("MISMATCH frame_start expected %h seen %h", f0, rx_fc);
            err_total++;
        end
        for (int k = 0; k < nf * 128; k++)
        begin
            check("word", exp_word(rx_pos, rx_fc), rx_word);
            check("slot", 8'(k % 128), {1'b0, rx_pos});
            check("frame", f0 + 8'(k / 128), rx_fc);
            get_word;
        end
    endtask
    // Reset in mid-word: the stream restarts at slot 0 of frame 0
    task automatic t_mid_reset;
        repeat (5) get_word;
        repeat (7) @(posedge clock);
        nrst <= 1'b0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        get_word;
        check("restart slot", 8'h0, {1'b0, rx_pos});
        check("restart frame", 8'h0, rx_fc);
    endtask
    task automatic end_of_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        nrst      = 1'b0;
        fmt_wr    = 1'b0;
        fmt_addr  = 7'h0;
        fmt_wdata = 8'h0;
        err_total = 0;
        compares  = 0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        t_load_format;
        t_frames(8'h1, 4);
        t_mid_reset;
        t_frames(8'h1, 1);
        end_of_test;
    end
    // Watchdog: the run needs about 30000 clocks
    initial
    begin
        repeat (60000) @(posedge clock);
        err_total++;
        end_of_test;
    end
endmodule // tb_telemetry_frame_formatter
